// ==== adc_output_lane_mapper_hpf_tb.sv ====
// Self-checking bench for the lane mapper output path
`timescale 1ns/1ns
`include "aolm_defines.svh"
module adc_output_lane_mapper_hpf_tb;
    import aolm_pkg::*;
    typedef struct {
        logic [11:0] ctrl;
        logic [6:0]  idx;
        logic [11:0] map;
        logic [2:0]  lane;
        logic [2:0]  src;
    } aolmh_row_s;
    logic         clk = 0, link_clk = 0, rst_n = 0;
    logic         wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
    logic [8:0]   wb_adr_i = 0;
    logic [31:0]  wb_dat_i = 0, wb_dat_o, rdat;
    logic [111:0] ain;
    logic [7:0]   la, lb, lae, lbe;
    logic         bclk, fclk, rx_two = 0, rx_msb = 0;
    logic [2:0]   rx_lane = 0;
    logic [13:0]  word;
    int           words, flen, fhigh, bhigh, b, len;
    int           err_count = 0, comparisons = 0, cycles = 0;
    logic [3:0]   codes [3] = '{4'h8, 4'hf, 4'h1};
    aolmh_row_s   rows [9] = '{
        '{12'h400, 7'h50, 12'h210, 3'h0, 3'h0}, '{12'h400, 7'h55, 12'h001, 3'h7, 3'h7},
        '{12'h401, 7'h52, 12'h076, 3'h3, 3'h3}, '{12'h402, 7'h53, 12'h567, 3'h4, 3'h4},
        '{12'h405, 7'h54, 12'h234, 3'h5, 3'h5}, '{12'h408, 7'h54, 12'h234, 3'h6, 3'h6},
        '{12'h400, 7'h50, 12'h216, 3'h0, 3'h3}, '{12'h400, 7'h53, 12'h503, 3'h4, 3'h7},
        '{12'h401, 7'h51, 12'h102, 3'h2, 3'h0}};
    always #10 clk = ~clk;
    always #3 link_clk = ~link_clk;
    aolm_lane_mapper dut (.clk(clk), .rst_n(rst_n), .link_clk(link_clk), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'h3),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .analog_input_data(ain), .lane_a_output(la), .lane_b_output(lb),
        .lane_a_enable(lae), .lane_b_enable(lbe), .bit_clock_out(bclk),
        .frame_clock_out(fclk));
    aolmh_rx rx (.link_clk(link_clk), .rst_n(rst_n), .lane(rx_lane), .two_wire(rx_two),
        .msb_first(rx_msb), .lane_a(la), .lane_b(lb), .bclk(bclk), .fclk(fclk),
        .word(word), .words(words), .flen(flen), .fhigh(fhigh), .bhigh(bhigh));
    function automatic logic [13:0] chan_val(input int c);
        return 14'(14'h0a53 + c * 14'h0611);
    endfunction : chan_val
    task automatic give_verdict;
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict
    task automatic cmp(input string what, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s at %0t got %h exp %h", what, $time, got, exp);
        end
    endtask : cmp
    task automatic bus(input logic we, input logic [6:0] idx, input logic [31:0] wd);
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= wd;
        do @(posedge clk); while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : bus
    task automatic wait_words(input int k);
        int w;
        w = words + k;
        while (words < w) @(posedge link_clk);
    endtask : wait_words
    task automatic cfg(input aolmh_row_s r);
        rx_lane = r.lane;
        rx_two = r.ctrl[0];
        rx_msb = r.ctrl[3];
        bus(1'b1, `AOLM_IDX_CTRL, 32'(r.ctrl));
        bus(1'b1, r.idx, 32'(r.map));
        do bus(1'b0, `AOLM_IDX_STAT, 32'h0); while (rdat[0] !== 1'b0);
        wait_words(3);
    endtask : cfg
    task automatic check_regs;
        logic [11:0] rv [7];
        rv = '{`AOLM_MAP_RST0, `AOLM_MAP_RST1, `AOLM_MAP_RST2, `AOLM_MAP_RST3,
               `AOLM_MAP_RST4, `AOLM_MAP_RST5, `AOLM_CTRL_RST};
        for (int i = 0; i < 7; i++) begin
            bus(1'b0, i < 6 ? 7'(`AOLM_IDX_MAP_FIRST + i) : `AOLM_IDX_CTRL, 32'h0);
            cmp("reset value", rdat, 32'(rv[i]));
        end
        $display("Test register reset values done");
    endtask : check_regs
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            err_count++;
            give_verdict();
        end
    end
    initial begin
        for (int c = 0; c < 8; c++) ain[c*14 +: 14] = chan_val(c);
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        check_regs();
        wait_words(12);
        foreach (rows[i]) begin
            cfg(rows[i]);
            b = rows[i].ctrl[2:1] == 2'h1 ? 12 : rows[i].ctrl[2:1] == 2'h2 ? 10 : 14;
            len = rows[i].ctrl[0] ? b / 2 : b;
            cmp("word", 32'(word), 32'(chan_val(rows[i].src) >> (14 - b)));
            cmp("frame length", flen, len);
            cmp("frame clock", fhigh, (len + 1) / 2);
            cmp("bit clock", bhigh, (len + 1) / 2);
            cmp("lane on", 32'(lae[rows[i].lane]), 32'h1);
            bus(1'b0, `AOLM_IDX_CTRL, 32'h0);
            cmp("ctrl", rdat, 32'(rows[i].ctrl));
            $display("Test row %0d done", i);
        end
        cfg('{12'h210, 7'h50, 12'h216, 3'h0, 3'h3});
        wait_words(150);
        cmp("filtered", 32'(word), 32'h2000);
        cfg('{12'h400, 7'h50, 12'h216, 3'h0, 3'h3});
        cmp("bypass", 32'(word), 32'(chan_val(3)));
        $display("Test high-pass done");
        bus(1'b1, 7'h7f, 32'hffff_ffff);
        bus(1'b0, 7'h7f, 32'h0);
        cmp("unmapped", rdat, 32'h0);
        foreach (codes[i]) begin
            cfg('{12'h400, 7'h50, {8'h21, codes[i]}, 3'h0, 3'h0});
            cmp("lane on", 32'(lae[0]), 32'(!codes[i][3]));
            repeat (30) begin
                @(posedge link_clk);
                cmp("quiet lane", 32'(la[0]), 32'h0);
            end
        end
        $display("Test refused codes done");
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        check_regs();
        rx_lane = 3'h0;
        wait_words(14);
        cmp("word", 32'(word), 32'(chan_val(0)));
        cmp("b lanes on", 32'(lbe), 32'hff);
        repeat (40) begin
            @(posedge link_clk);
            cmp("b lanes", 32'(lb), 32'h0);
        end
        $display("Test second reset done");
        give_verdict();
    end
endmodule : adc_output_lane_mapper_hpf_tb

// ==== aolm_defines.svh ====
// Register offsets, reset values, field positions and counts of the lane mapper
`ifndef AOLM_DEFINES_SVH
`define AOLM_DEFINES_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define AOLM_IDX_CTRL       7'h40
`define AOLM_IDX_STAT       7'h41
`define AOLM_IDX_MAP_FIRST  7'h50
`define AOLM_IDX_MAP_LAST   7'h55

// ****************************************************************
// Reset values
// ****************************************************************
`define AOLM_MAP_RST0       12'h210
`define AOLM_MAP_RST1       12'h543
`define AOLM_MAP_RST2       12'h076
`define AOLM_MAP_RST3       12'h567
`define AOLM_MAP_RST4       12'h234
`define AOLM_MAP_RST5       12'h001
`define AOLM_CTRL_RST       12'h400

// ****************************************************************
// Control and status field positions
// ****************************************************************
`define AOLM_CTRL_TWO_WIRE  0
`define AOLM_CTRL_RES_LO    1
`define AOLM_CTRL_RES_HI    2
`define AOLM_CTRL_MSB_FIRST 3
`define AOLM_CTRL_HPF_EN    4
`define AOLM_CTRL_K_LO      8
`define AOLM_CTRL_K_HI      11
`define AOLM_STAT_BUSY      0
`define AOLM_STAT_CNT_LO    16

// ****************************************************************
// Select field and counts
// ****************************************************************
`define AOLM_SEL_OFF_BIT    3
`define AOLM_FIELDS_PER_REG 3
`define AOLM_LATENCY        11
`define AOLM_K_MIN          4'd2
`define AOLM_K_MAX          4'd10
`define AOLM_HPF_FRAC       8
`define AOLM_BITS_14        4'd14
`define AOLM_BITS_12        4'd12
`define AOLM_BITS_10        4'd10

`endif

// ==== aolm_hpf.sv ====
// First-order high-pass filter for one channel, fixed point
`timescale 1ns/1ns
`include "aolm_defines.svh"

module aolm_hpf (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              step,
    input  wire logic              enable,
    input  wire logic [3:0]        k,
    input  wire aolm_pkg::aolm_word_t x_in,
    output aolm_pkg::aolm_word_t   y_out
);
    import aolm_pkg::*;

    localparam int F  = `AOLM_HPF_FRAC;
    localparam int SW = 14 + F + 3;

    logic signed [SW-1:0] xp;
    logic signed [SW-1:0] yp;
    wire  signed [SW-1:0] xs   = SW'($signed({~x_in[13], x_in[12:0]})) <<< F;
    wire  signed [SW-1:0] s    = xs - xp + yp;
    wire  signed [SW-1:0] ms   = s - (s >>> k) + (s >>> (2 * k)) - (s >>> (3 * k));
    wire  signed [SW-1:0] rnd  = ms[SW-1] ? ms + SW'((1 << F) - 1) : ms;
    wire  signed [SW-1:0] yi   = rnd >>> F;
    wire                  hi   = yi > SW'(8191);
    wire                  lo   = yi < -SW'(8192);
    wire  [13:0]          ysat = hi ? 14'h1fff : (lo ? 14'h2000 : yi[13:0]);

    assign y_out = enable ? {~ysat[13], ysat[12:0]} : x_in;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            xp <= '0;
            yp <= '0;
        end else if (step) begin
            xp <= xs;
            yp <= enable ? ms : '0;
        end
    end

    a_hpf_bypass: assert property (@(posedge clk) disable iff (!rst_n)
        !enable |-> y_out == x_in) else $error("Filter not transparent when off");
endmodule : aolm_hpf

// ==== aolm_lane_mapper.sv ====
// Output path: latency pipe, high-pass filters, lane crossbar and serialisers
// Notes on behaviour
// - All eight channels captured on one edge
// - Samples leave pipe eleven sample periods later
// - Word sent on one lane or two
// - Bit clock 7x, frame clock 1x rate
// - Resolution selectable 14, 12 or 10 bits
// - Four-bit select per lane, registers 0x50-0x55
// - First group codes pick inputs one to four
// - Second group codes pick inputs eight down
// - Even whole/low half, odd high half only
// - Select MSB set powers lane down
// - Reset 1-wire: input k on lane kA
// - Reset 2-wire: kA low, kB high half
// - High-pass IIR with m = 2^k/(2^k+1)
// - Exponent k configurable from 2 to 10
// - Groups never cross between input halves
// - LSB first by default, MSB option
//
// Local design decisions: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ns
`include "aolm_defines.svh"

module aolm_lane_mapper #(
    parameter int LATENCY = `AOLM_LATENCY,
    parameter int WORD_W  = 14
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        link_clk,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [8:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic [111:0] analog_input_data,
    output logic      [7:0]  lane_a_output,
    output logic      [7:0]  lane_b_output,
    output logic      [7:0]  lane_a_enable,
    output logic      [7:0]  lane_b_enable,
    output logic             bit_clock_out,
    output logic             frame_clock_out
);
    import aolm_pkg::*;

    if (LATENCY < 1 || WORD_W != 14) begin : g_bad_param
        $error("Unsupported latency or word width");
    end

    // ****************************************************************
    // Functions
    // ****************************************************************
    function automatic logic [2:0] src_of(input logic grp, input aolm_sel_t code);
        src_of = grp ? 3'(3'd7 - {1'b0, code[2:1]}) : {1'b0, code[2:1]};
    endfunction : src_of

    function automatic logic [11:0] merge(input logic [11:0] old, input logic [3:0] sel,
                                          input logic [31:0] d);
        merge = {sel[1] ? d[11:8] : old[11:8], sel[0] ? d[7:0] : old[7:0]};
    endfunction : merge

    // ****************************************************************
    // Wishbone slave
    // ****************************************************************
    logic        [11:0] map_reg [6];
    logic        [11:0] ctrl;
    logic               busy;
    logic               dirty;
    logic        [15:0] frame_cnt;
    wire         [6:0]  idx     = wb_adr_i[8:2];
    wire                req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire                hit_map = idx >= `AOLM_IDX_MAP_FIRST && idx <= `AOLM_IDX_MAP_LAST;
    wire         [2:0]  map_i   = 3'(idx - `AOLM_IDX_MAP_FIRST);
    wire                hit_ctl = idx == `AOLM_IDX_CTRL;
    wire                hit_sta = idx == `AOLM_IDX_STAT;
    wire                wr      = req && wb_we_i;
    wire         [31:0] stat_w  = (32'(frame_cnt) << `AOLM_STAT_CNT_LO) |
                                  (32'(busy || dirty) << `AOLM_STAT_BUSY);
    wire         [31:0] rd_w    = hit_map ? 32'(map_reg[map_i]) :
                                  hit_ctl ? 32'(ctrl) : hit_sta ? stat_w : 32'h0;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= req ? rd_w : 32'h0;
        end
    end

    // Default mapping serves both wire modes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            map_reg[0] <= `AOLM_MAP_RST0;
            map_reg[1] <= `AOLM_MAP_RST1;
            map_reg[2] <= `AOLM_MAP_RST2;
            map_reg[3] <= `AOLM_MAP_RST3;
            map_reg[4] <= `AOLM_MAP_RST4;
            map_reg[5] <= `AOLM_MAP_RST5;
            ctrl       <= `AOLM_CTRL_RST;
        end else if (wr) begin
            if (hit_map) begin
                map_reg[map_i] <= merge(map_reg[map_i], wb_sel_i, wb_dat_i);
            end
            if (hit_ctl) begin
                ctrl <= merge(ctrl, wb_sel_i, wb_dat_i);
            end
        end
    end

    // ****************************************************************
    // Configuration crossing (toggle handshake, held shadow)
    // ****************************************************************
    localparam int CW = 12 + 72;
    logic [CW-1:0] xfer;
    logic          req_tgl;
    logic          ack_s1;
    logic          ack_s2;
    logic          ack_tgl;
    wire  [CW-1:0] live = {ctrl, map_reg[5], map_reg[4], map_reg[3],
                           map_reg[2], map_reg[1], map_reg[0]};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            xfer    <= {`AOLM_CTRL_RST, `AOLM_MAP_RST5, `AOLM_MAP_RST4, `AOLM_MAP_RST3,
                        `AOLM_MAP_RST2, `AOLM_MAP_RST1, `AOLM_MAP_RST0};
            dirty   <= 1'b0;
            req_tgl <= 1'b0;
            busy    <= 1'b0;
            ack_s1  <= 1'b0;
            ack_s2  <= 1'b0;
        end else begin
            ack_s1 <= ack_tgl;
            ack_s2 <= ack_s1;
            if (!busy && dirty) begin
                xfer    <= live;
                req_tgl <= ~req_tgl;
                busy    <= 1'b1;
            end else if (busy && ack_s2 == req_tgl) begin
                busy <= 1'b0;
            end
            dirty <= (wr && (hit_map || hit_ctl)) || (dirty && !(!busy));
        end
    end

    // ****************************************************************
    // Link domain reset and configuration capture
    // ****************************************************************
    logic          lrst_s1;
    logic          lrst_n_q;
    logic          req_s1;
    logic          req_s2;
    logic [CW-1:0] cfg_l;
    logic          frm_tgl;
    logic [3:0]    cnt;

    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            lrst_s1  <= 1'b0;
            lrst_n_q <= 1'b0;
        end else begin
            lrst_s1  <= 1'b1;
            lrst_n_q <= lrst_s1;
        end
    end

    wire [11:0] ctrl_l    = cfg_l[CW-1 -: 12];
    wire        two_wire  = ctrl_l[`AOLM_CTRL_TWO_WIRE];
    wire [1:0]  res_code  = ctrl_l[`AOLM_CTRL_RES_HI:`AOLM_CTRL_RES_LO];
    wire        msb_first = ctrl_l[`AOLM_CTRL_MSB_FIRST];
    wire        hpf_en    = ctrl_l[`AOLM_CTRL_HPF_EN];
    wire [3:0]  k_raw     = ctrl_l[`AOLM_CTRL_K_HI:`AOLM_CTRL_K_LO];
    wire [3:0]  k_eff     = k_raw < `AOLM_K_MIN ? `AOLM_K_MIN :
                            (k_raw > `AOLM_K_MAX ? `AOLM_K_MAX : k_raw);
    wire [3:0]  res_bits  = res_code == AOLM_RES_12 ? `AOLM_BITS_12 :
                            (res_code == AOLM_RES_10 ? `AOLM_BITS_10 : `AOLM_BITS_14);
    wire [3:0]  len       = two_wire ? (res_bits >> 1) : res_bits;
    wire [3:0]  len_m1    = len - 4'd1;
    wire        fstart    = cnt == len_m1;
    wire [3:0]  nxt_cnt   = fstart ? 4'd0 : cnt + 4'd1;
    wire [3:0]  bit_idx   = msb_first ? 4'(len_m1 - nxt_cnt) : nxt_cnt;
    wire        cfg_new   = req_s2 != ack_tgl;

    always_ff @(posedge link_clk or negedge lrst_n_q) begin
        if (!lrst_n_q) begin
            req_s1  <= 1'b0;
            req_s2  <= 1'b0;
            ack_tgl <= 1'b0;
            cfg_l   <= {`AOLM_CTRL_RST, `AOLM_MAP_RST5, `AOLM_MAP_RST4, `AOLM_MAP_RST3,
                        `AOLM_MAP_RST2, `AOLM_MAP_RST1, `AOLM_MAP_RST0};
            cnt     <= `AOLM_BITS_14 - 4'd1;
            frm_tgl <= 1'b0;
        end else begin
            req_s1 <= req_tgl;
            req_s2 <= req_s1;
            cnt    <= nxt_cnt;
            if (fstart) begin
                frm_tgl <= ~frm_tgl;
                if (cfg_new) begin
                    cfg_l   <= xfer;
                    ack_tgl <= req_s2;
                end
            end
        end
    end

    // ****************************************************************
    // Frame counter back in the bus domain
    // ****************************************************************
    logic frm_s1;
    logic frm_s2;
    logic frm_s3;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            frm_s1    <= 1'b0;
            frm_s2    <= 1'b0;
            frm_s3    <= 1'b0;
            frame_cnt <= 16'h0;
        end else begin
            frm_s1    <= frm_tgl;
            frm_s2    <= frm_s1;
            frm_s3    <= frm_s2;
            frame_cnt <= frame_cnt + 16'(frm_s2 ^ frm_s3);
        end
    end

    // ****************************************************************
    // Sample capture, latency pipe and filters
    // ****************************************************************
    aolm_word_t pipe [LATENCY][8];
    aolm_word_t filt [8];
    aolm_word_t wres [8];

    // One shared capture edge, fixed depth
    always_ff @(posedge link_clk or negedge lrst_n_q) begin
        if (!lrst_n_q) begin
            pipe <= '{default: '0};
        end else if (fstart) begin
            for (int c = 0; c < 8; c++) begin
                pipe[0][c] <= analog_input_data[c*14 +: 14];
                for (int s = 1; s < LATENCY; s++) begin
                    pipe[s][c] <= pipe[s-1][c];
                end
            end
        end
    end

    genvar gc;
    generate
        for (gc = 0; gc < 8; gc++) begin : g_ch
            aolm_hpf u_hpf (
                .clk    (link_clk),
                .rst_n  (lrst_n_q),
                .step   (fstart),
                .enable (hpf_en),
                .k      (k_eff),
                .x_in   (pipe[LATENCY-1][gc]),
                .y_out  (filt[gc])
            );
            assign wres[gc] = filt[gc] >> (`AOLM_BITS_14 - res_bits);
        end
    endgenerate

    // ****************************************************************
    // Crossbar and serialisers
    // ****************************************************************
    aolm_sel_t  sel_l [16];
    aolm_word_t chunk [16];
    aolm_word_t word  [16];
    logic [15:0] lane_ok;
    logic [15:0] lane_q;
    logic [15:0] lane_en_q;
    logic        bclk_q;
    logic        fclk_q;

    genvar gg, gf, gl;
    generate
        for (gg = 0; gg < 2; gg++) begin : g_grp
            for (gf = 0; gf < 8; gf++) begin : g_fld
                localparam int R    = gg * 3 + gf / `AOLM_FIELDS_PER_REG;
                localparam int S    = gf % `AOLM_FIELDS_PER_REG;
                localparam int LANE = gg ? 8 + (gf ^ 1) : gf;
                assign sel_l[LANE] = cfg_l[R*12 + S*4 +: 4];
            end
        end
        for (gl = 0; gl < 16; gl++) begin : g_lane
            wire [2:0] src = src_of(gl >= 8, sel_l[gl]);
            // Odd codes only in 2-wire, carry high half
            assign lane_ok[gl] = !sel_l[gl][`AOLM_SEL_OFF_BIT] && (two_wire || !sel_l[gl][0]);
            assign chunk[gl]   = (two_wire && sel_l[gl][0]) ? wres[src] >> len : wres[src];
            wire   [13:0] cur  = fstart ? chunk[gl] : word[gl];

            always_ff @(posedge link_clk or negedge lrst_n_q) begin
                if (!lrst_n_q) begin
                    word[gl]      <= 14'h0;
                    lane_q[gl]    <= 1'b0;
                    lane_en_q[gl] <= 1'b0;
                end else begin
                    if (fstart) begin
                        word[gl] <= chunk[gl];
                    end
                    lane_q[gl]    <= lane_ok[gl] && cur[bit_idx];
                    // Driver off when select MSB set
                    lane_en_q[gl] <= !sel_l[gl][`AOLM_SEL_OFF_BIT];
                end
            end
            if (gl % 2 == 0) begin : g_a
                assign lane_a_output[gl/2] = lane_q[gl];
                assign lane_a_enable[gl/2] = lane_en_q[gl];
            end else begin : g_b
                assign lane_b_output[gl/2] = lane_q[gl];
                assign lane_b_enable[gl/2] = lane_en_q[gl];
            end
        end
    endgenerate

    // Bit clock toggles per bit, frame clock per word
    always_ff @(posedge link_clk or negedge lrst_n_q) begin
        if (!lrst_n_q) begin
            bclk_q <= 1'b0;
            fclk_q <= 1'b0;
        end else begin
            bclk_q <= fstart ? 1'b1 : ~bclk_q;
            fclk_q <= nxt_cnt < ((len + 4'd1) >> 1);
        end
    end

    assign bit_clock_out   = bclk_q;
    assign frame_clock_out = fclk_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    logic [7:0] stable_cnt;
    always_ff @(posedge link_clk or negedge lrst_n_q) begin
        if (!lrst_n_q) begin
            stable_cnt <= 8'h0;
        end else begin
            stable_cnt <= (fstart && cfg_new) ? 8'h0 : stable_cnt + 8'(stable_cnt != 8'hff);
        end
    end

    sequence s_wb_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence

    a_wb_ack_once: assert property (@(posedge clk) disable iff (!rst_n)
        s_wb_req |=> wb_ack_o ##1 !wb_ack_o) else $error("Bus answer not one cycle");
    a_cfg_xfer_done: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(busy) |-> ##[1:30] !busy) else $error("Config crossing stuck");
    a_pipe_latency: assert property (@(posedge link_clk) disable iff (!lrst_n_q)
        (fstart && stable_cnt == 8'hff && len == `AOLM_BITS_14)
        |-> pipe[LATENCY-1][0] == $past(analog_input_data[13:0], LATENCY * `AOLM_BITS_14))
        else $error("Sample latency wrong");
    a_frame_count: assert property (@(posedge link_clk) disable iff (!lrst_n_q)
        fstart |=> cnt == 4'd0 ##1 cnt == 4'd1) else $error("Frame counter wrong");
    a_fclk_rise: assert property (@(posedge link_clk) disable iff (!lrst_n_q)
        $rose(fclk_q) |-> $past(fstart)) else $error("Frame clock off frame start");
    a_bclk_toggle: assert property (@(posedge link_clk) disable iff (!lrst_n_q)
        !$past(fstart) |-> bclk_q != $past(bclk_q)) else $error("Bit clock stalled");
    a_lsb_first: assert property (@(posedge link_clk) disable iff (!lrst_n_q)
        (fstart && !msb_first && lane_ok[0]) |=> lane_q[0] == $past(chunk[0][0]))
        else $error("First bit not LSB");
    a_lane_down: assert property (@(posedge link_clk) disable iff (!lrst_n_q)
        sel_l[0][3] |=> !lane_en_q[0] && !lane_q[0]) else $error("Lane not powered down");
endmodule : aolm_lane_mapper

// ==== aolm_pkg.sv ====
// Types shared by the lane mapper and its high-pass filter
package aolm_pkg;
    typedef logic [3:0]  aolm_sel_t;
    typedef logic [13:0] aolm_word_t;
    typedef logic [11:0] aolm_field_t;
    typedef enum logic [1:0] {
        AOLM_RES_14 = 2'h0,
        AOLM_RES_12 = 2'h1,
        AOLM_RES_10 = 2'h2
    } aolm_res_e;
endpackage : aolm_pkg

// ==== aolmh_rx.sv ====
// Capture receiver model for the serial lanes
`timescale 1ns/1ns
module aolmh_rx (
    input  wire logic        link_clk,
    input  wire logic        rst_n,
    input  wire logic [2:0]  lane,
    input  wire logic        two_wire,
    input  wire logic        msb_first,
    input  wire logic [7:0]  lane_a,
    input  wire logic [7:0]  lane_b,
    input  wire logic        bclk,
    input  wire logic        fclk,
    output logic      [13:0] word,
    output int               words,
    output int               flen,
    output int               fhigh,
    output int               bhigh
);
    logic [13:0] acc_a;
    logic [13:0] acc_b;
    logic        fclk_q;
    int          n;
    int          nf;
    int          nb;
    wire         start = fclk && !fclk_q;
    function automatic logic [13:0] put(logic [13:0] acc, logic b, int pos);
        return msb_first ? {acc[12:0], b} : acc | (14'(b) << pos);
    endfunction : put
    always @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            fclk_q <= 1'b1;
            words <= 0;
            word <= 14'h0;
            n <= 0;
        end else begin
            fclk_q <= fclk;
            if (start && n > 0) begin
                word <= two_wire ? 14'((acc_b << n) | acc_a) : acc_a;
                words <= words + 1;
                flen <= n;
                fhigh <= nf;
                bhigh <= nb;
            end
            acc_a <= put(start ? 14'h0 : acc_a, lane_a[lane], start ? 0 : n);
            acc_b <= put(start ? 14'h0 : acc_b, lane_b[lane], start ? 0 : n);
            n <= start ? 1 : n + 1;
            nf <= (start ? 0 : nf) + int'(fclk);
            nb <= (start ? 0 : nb) + int'(bclk);
        end
    end
endmodule : aolmh_rx
